// ===== eepc_pkg.sv
// Purpose: Shared constants and carriers for the array program/erase control
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes:   Array holds 512 bytes in four 128-byte blocks
package eepc_pkg;

   // ---------------------------------------------------------------
   // Address map (register indices, byte address = index * 4)
   // ---------------------------------------------------------------
   localparam int             ADDR_W       = 18;
   localparam logic [15:0]    IDX_ARRAY    = 16'h0800;
   localparam logic [15:0]    IDX_NV_CFG   = 16'hfe1c;
   localparam logic [15:0]    IDX_CTRL     = 16'hfe1d;
   localparam logic [15:0]    IDX_SHADOW   = 16'hfe1f;
   localparam int             ARRAY_BYTES  = 512;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int             CTL_PCLK     = 7;
   localparam int             CTL_OFF      = 5;
   localparam int             CTL_RAS_HI   = 4;
   localparam int             CTL_RAS_LO   = 3;
   localparam int             CTL_LAT      = 2;
   localparam int             CTL_PGM      = 0;

   // ---------------------------------------------------------------
   // Configuration byte fields
   // ---------------------------------------------------------------
   localparam int             CFG_RED      = 7;
   localparam logic [7:0]     CFG_MASK     = 8'h8f;
   localparam logic [7:0]     NV_CFG_INIT  = 8'h00;
   localparam logic [7:0]     ERASED       = 8'hff;

   // ---------------------------------------------------------------
   // Modes and responses
   // ---------------------------------------------------------------
   localparam logic [1:0]     MODE_PROG    = 2'h0;
   localparam logic [1:0]     MODE_BYTE_ER = 2'h1;
   localparam logic [1:0]     MODE_BLK_ER  = 2'h2;
   localparam logic [1:0]     MODE_BULK_ER = 2'h3;
   localparam logic [1:0]     RESP_OKAY    = 2'h0;
   localparam logic [1:0]     RESP_SLVERR  = 2'h2;

   typedef struct packed {
      logic       en;
      logic [1:0] mode;
      logic       nvr;
      logic       red;
      logic [8:0] addr;
      logic [7:0] data;
   } eepc_op_s;

   typedef struct packed {
      logic       ok;
      logic       is_arr;
      logic       is_nvr;
      logic       is_ctl;
      logic       is_shd;
      logic [8:0] idx;
   } eepc_dec_s;

endpackage

// ===== eepc_cell_array.sv
// Purpose: Nonvolatile cell storage: 512 array bytes and the config byte
// Assumes: Operation stays applied while the charge pump is on
// Notes:   No reset here, contents survive every reset
`timescale 1ns/1ns
`default_nettype none
module eepc_cell_array
   import eepc_pkg::*;
(
   // Clock
   input  wire logic       aclk,
   // Operation from control
   input  wire eepc_op_s   op,
   // Read side
   input  wire logic [8:0] rd_idx,
   output logic [7:0]      rd_data,
   output logic [7:0]      nv_q
);

   // Array starts erased, config byte at NV_CFG_INIT, set once at time zero only
   logic [7:0] mem [ARRAY_BYTES] = '{default: ERASED};
   logic [7:0] nv                = NV_CFG_INIT;

   // ---------------------------------------------------------------
   // Program and erase
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (op.en) begin
         if (op.nvr) begin
            if (op.mode == MODE_PROG) begin
               nv <= nv & op.data;
            end else if (op.mode == MODE_BYTE_ER) begin
               nv <= ERASED;
            end
         end else begin
            for (int i = 0; i < ARRAY_BYTES; i++) begin
               case (op.mode)
                  MODE_PROG: begin
                     if (i[8:0] == op.addr || (op.red && i[8:0] == {1'b1, op.addr[7:0]})) begin
                        mem[i] <= mem[i] & op.data;
                     end
                  end
                  MODE_BYTE_ER: begin
                     if (i[8:0] == op.addr || (op.red && i[8:0] == {1'b1, op.addr[7:0]})) begin
                        mem[i] <= ERASED;
                     end
                  end
                  MODE_BLK_ER: begin
                     if (i[8:7] == op.addr[8:7] || (op.red && i[7] == op.addr[7])) begin
                        mem[i] <= ERASED;
                     end
                  end
                  default: begin
                     mem[i] <= ERASED;
                  end
               endcase
            end
         end
      end
   end

   assign rd_data = mem[rd_idx];
   assign nv_q    = nv;

endmodule
`default_nettype wire

// ===== eepc_ctrl.sv
// Purpose: Program/erase control, config shadow and AXI4-Lite slave
// Assumes: stop_mode comes from logic on aclk
// Notes:   Array and registers answer in the low byte, upper bits zero
`timescale 1ns/1ns
`default_nettype none
// Function
// - Stored config byte unchanged by reset
// - Reset copies config byte into shadow
// - Config byte read reloads the shadow
// - Config byte programmed like array, applied later
// - Pump clock select bit, reset clears
// - Power-down bit disables array, reset clears
// - Erase bits pick mode; protected blocks refused
// - Capture bit routes writes to latch
// - Capture cannot clear while enable set
// - High voltage needs capture and valid write
// - Clearing both clears only the enable
// - Shadow read-only, redundancy and protect bits
// - Redundancy bit selects mirrored configuration
// - Protect bits guard blocks, loaded at reset
// - Wait mode leaves operations untouched
// - Stop drops high voltage, resumes after
// - Four 128-byte blocks, lowest under bit 0
// - Redundant mode mirrors lower half
// - Later writes replace capture; reads return it
module eepc_ctrl
   import eepc_pkg::*;
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Power mode
   input  wire logic              stop_mode,
   // Pump and array control
   output logic                   pump_clock_select,
   output logic                   array_power_down,
   output logic                   charge_pump_on
);

   typedef struct packed {
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [7:0]        w_data;
      logic              w_lane0;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [7:0]        rdata;
      logic [1:0]        rresp;
      logic              pclk_sel;
      logic              pwr_down;
      logic [1:0]        erase_sel;
      logic              lat;
      logic              pgm;
      logic              hv_on;
      logic [7:0]        shadow;
      logic              cap_valid;
      logic              cap_nvr;
      logic [8:0]        cap_addr;
      logic [7:0]        cap_data;
   } eepc_state_s;

   eepc_state_s st;
   eepc_state_s next_st;
   eepc_op_s    op;
   eepc_dec_s   rd_dec;
   eepc_dec_s   wr_dec;
   logic [7:0]  arr_q;
   logic [7:0]  nv_q;
   logic [3:0]  prot_eff;
   logic        prot_hit;
   logic        hv_req;
   logic        wr_go;
   logic        rd_go;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   function automatic eepc_dec_s decode(input logic [ADDR_W-1:0] a, input logic red);
      eepc_dec_s   d;
      logic [15:0] idx;
      logic [15:0] off;
      d      = '0;
      idx    = a[ADDR_W-1:2];
      off    = idx - IDX_ARRAY;
      d.idx  = off[8:0];
      d.is_arr = (idx >= IDX_ARRAY) && (off < 16'(ARRAY_BYTES)) && !(red && off[8]);
      d.is_nvr = (idx == IDX_NV_CFG);
      d.is_ctl = (idx == IDX_CTRL);
      d.is_shd = (idx == IDX_SHADOW);
      d.ok     = (a[1:0] == 2'h0) && (d.is_arr || d.is_nvr || d.is_ctl || d.is_shd);
      return d;
   endfunction

   assign rd_dec = decode(araddr, st.shadow[CFG_RED]);
   assign wr_dec = decode(st.aw_addr, st.shadow[CFG_RED]);
   assign wr_go  = st.aw_held && st.w_held && !st.bvalid;
   assign rd_go  = arvalid && !st.rvalid;

   // ---------------------------------------------------------------
   // Protection and high-voltage gating
   // ---------------------------------------------------------------
   assign prot_eff = st.shadow[CFG_RED] ? {2'b00, st.shadow[1:0]} : st.shadow[3:0];
   always_comb begin
      if (st.cap_nvr) begin
         prot_hit = 1'b0;
      end else if (st.erase_sel == MODE_BULK_ER) begin
         prot_hit = |prot_eff;
      end else begin
         prot_hit = prot_eff[st.cap_addr[8:7]];
      end
   end
   // Wait mode is not an input: it cannot touch the operation
   assign hv_req = st.pgm && st.lat && st.cap_valid && !stop_mode && !prot_hit;

   assign op.en   = st.hv_on;
   assign op.mode = st.erase_sel;
   assign op.nvr  = st.cap_nvr;
   assign op.red  = st.shadow[CFG_RED];
   assign op.addr = st.cap_addr;
   assign op.data = st.cap_data;

   eepc_cell_array u_cells (
      .aclk    (aclk),
      .op      (op),
      .rd_idx  (rd_dec.idx),
      .rd_data (arr_q),
      .nv_q    (nv_q)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st       = st;
      next_st.hv_on = hv_req;
      if (awvalid && !st.aw_held) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = awaddr;
      end
      if (wvalid && !st.w_held) begin
         next_st.w_held  = 1'b1;
         next_st.w_data  = wdata[7:0];
         next_st.w_lane0 = wstrb[0];
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end
      if (wr_go) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = wr_dec.ok ? RESP_OKAY : RESP_SLVERR;
         if (wr_dec.ok && st.w_lane0) begin
            if ((wr_dec.is_arr || wr_dec.is_nvr) && st.lat && !st.pgm) begin
               next_st.cap_valid = 1'b1;
               next_st.cap_nvr   = wr_dec.is_nvr;
               next_st.cap_addr  = wr_dec.idx;
               next_st.cap_data  = st.w_data;
            end
            if (wr_dec.is_ctl) begin
               next_st.pclk_sel = st.w_data[CTL_PCLK];
               next_st.pwr_down = st.w_data[CTL_OFF];
               if (!st.pgm) begin
                  next_st.erase_sel = {st.w_data[CTL_RAS_HI], st.w_data[CTL_RAS_LO]};
               end
               if (st.w_data[CTL_LAT]) begin
                  next_st.lat = 1'b1;
               end else if (!st.pgm) begin
                  next_st.lat = 1'b0;
               end
               if (!st.w_data[CTL_PGM]) begin
                  next_st.pgm = 1'b0;
               end else if (next_st.lat && st.cap_valid) begin
                  next_st.pgm = 1'b1;
               end
            end
         end
      end
      if (!next_st.lat) begin
         next_st.cap_valid = 1'b0;
      end
      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      if (rd_go) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = rd_dec.ok ? RESP_OKAY : RESP_SLVERR;
         next_st.rdata  = 8'h00;
         if (rd_dec.is_arr && !st.pwr_down) begin
            next_st.rdata = (st.lat && st.cap_valid) ? st.cap_data : arr_q;
         end
         if (rd_dec.is_nvr) begin
            next_st.rdata  = nv_q & CFG_MASK;
            next_st.shadow = nv_q & CFG_MASK;
         end
         if (rd_dec.is_ctl) begin
            next_st.rdata = {st.pclk_sel, 1'b0, st.pwr_down, st.erase_sel, st.lat, 1'b0, st.pgm};
         end
         if (rd_dec.is_shd) begin
            next_st.rdata = st.shadow;
         end
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st        <= '0;
         st.shadow <= nv_q & CFG_MASK;
      end else begin
         st <= next_st;
      end
   end

   assign awready           = !st.aw_held;
   assign wready            = !st.w_held;
   assign bvalid            = st.bvalid;
   assign bresp             = st.bresp;
   assign arready           = !st.rvalid;
   assign rvalid            = st.rvalid;
   assign rresp             = st.rresp;
   assign rdata             = {24'h000000, st.rdata};
   assign pump_clock_select = st.pclk_sel;
   assign array_power_down  = st.pwr_down;
   assign charge_pump_on    = st.hv_on;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_stop_left;
      stop_mode ##1 !stop_mode;
   endsequence

   property p_pgm_needs_capture;
      $rose(st.pgm) |-> st.lat && st.cap_valid;
   endproperty
   a_pgm_needs_capture: assert property (p_pgm_needs_capture)
      else $error("enable set without capture");

   property p_lat_held;
      st.pgm |=> st.lat;
   endproperty
   a_lat_held: assert property (p_lat_held)
      else $error("capture cleared while enable set");

   property p_stop_drops_hv;
      stop_mode |=> !charge_pump_on;
   endproperty
   a_stop_drops_hv: assert property (p_stop_drops_hv)
      else $error("high voltage during stop");

   property p_stop_resume;
      s_stop_left ##0 (st.pgm && st.lat && st.cap_valid && !prot_hit) |=> charge_pump_on;
   endproperty
   a_stop_resume: assert property (p_stop_resume)
      else $error("high voltage not restored after stop");

   property p_shadow_reload;
      rd_go && rd_dec.is_nvr |=> st.shadow == ($past(nv_q) & CFG_MASK);
   endproperty
   a_shadow_reload: assert property (p_shadow_reload)
      else $error("shadow not reloaded on read");

   property p_shadow_reserved;
      st.shadow[6:4] == 3'h0;
   endproperty
   a_shadow_reserved: assert property (p_shadow_reserved)
      else $error("shadow reserved bits set");

   property p_protect_blocks_hv;
      charge_pump_on |-> !$past(prot_hit);
   endproperty
   a_protect_blocks_hv: assert property (p_protect_blocks_hv)
      else $error("high voltage on protected target");

   property p_mode_frozen;
      st.pgm && $past(st.pgm) |-> $stable(st.erase_sel);
   endproperty
   a_mode_frozen: assert property (p_mode_frozen)
      else $error("mode changed during operation");

   property p_write_answer;
      wr_go |=> bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer)
      else $error("write response missing");

   property p_capture_drops;
      !st.lat |-> !st.cap_valid;
   endproperty
   a_capture_drops: assert property (p_capture_drops)
      else $error("capture valid with latching off");

endmodule
`default_nettype wire

// ===== tb_eeprom_program_erase_control.sv
// Purpose: Self-checking bench for the array program/erase control
// Assumes: Stored config byte starts at 8'h00 and the array starts erased
// Notes:   Driver queues expected answers, a monitor compares them
`timescale 1ns/1ns
`default_nettype none
module tb_eeprom_program_erase_control
   import eepc_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic              aclk      = 1'b0;
   logic              aresetn   = 1'b0;
   logic [ADDR_W-1:0] awaddr    = '0;
   logic              awvalid   = 1'b0;
   logic              awready;
   logic [31:0]       wdata     = '0;
   logic [3:0]        wstrb     = 4'h1;
   logic              wvalid    = 1'b0;
   logic              wready;
   logic [1:0]        bresp;
   logic              bvalid;
   logic              bready    = 1'b0;
   logic [ADDR_W-1:0] araddr    = '0;
   logic              arvalid   = 1'b0;
   logic              arready;
   logic [31:0]       rdata;
   logic [1:0]        rresp;
   logic              rvalid;
   logic              rready    = 1'b0;
   logic              stop_mode = 1'b0;
   logic              pump_clock_select;
   logic              array_power_down;
   logic              charge_pump_on;
   int                n_fail    = 0;
   int                compares  = 0;
   int                cyc       = 0;
   logic [34:0]       rq[$];
   logic [1:0]        bq[$];
   logic [34:0]       r_e;
   logic [7:0]        mem[ARRAY_BYTES];
   logic [7:0]        nv        = NV_CFG_INIT;
   logic [7:0]        shd;
   logic [15:0]       base;
   logic [7:0]        dat;
   logic [1:0]        tbl[8]    = '{MODE_PROG, MODE_PROG, MODE_BYTE_ER, MODE_PROG,
                                    MODE_BLK_ER, MODE_PROG, MODE_PROG, MODE_BULK_ER};

   always #4 aclk = ~aclk;

   eepc_ctrl u_eepc_ctrl (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .stop_mode(stop_mode), .pump_clock_select(pump_clock_select),
      .array_power_down(array_power_down), .charge_pump_on(charge_pump_on)
   );

   // ---------------------------------------------------------------
   // Checking and closing
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (n_fail == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready === 1'b1) begin
         if (rq.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            r_e = rq.pop_front();
            check(32'(rresp), 32'(r_e[1:0]));
            if (r_e[34]) check(rdata, r_e[33:2]);
         end
      end
      if (bvalid === 1'b1 && bready === 1'b1) begin
         if (bq.size() == 0) check(32'h1, 32'h0);
         else check(32'(bresp), 32'(bq.pop_front()));
      end
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         stop_test();
      end
   end

   // ---------------------------------------------------------------
   // Bus master and model
   // ---------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] ba(input logic [15:0] idx);
      return {idx, 2'b00};
   endfunction

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw_d;
      logic w_d;
      @(posedge aclk);
      bq.push_back(er);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      aw_d = 1'b0;
      w_d  = 1'b0;
      while (!(aw_d && w_d)) begin
         @(posedge aclk);
         if (!aw_d && awready === 1'b1) begin
            aw_d = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_d && wready === 1'b1) begin
            w_d = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er,
                     input logic care);
      @(posedge aclk);
      rq.push_back({care, 24'h0, d, er});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rready <= 1'b0;
   endtask

   task automatic outs(input logic [2:0] e);
      repeat (2) @(posedge aclk);
      check({29'h0, pump_clock_select, array_power_down, charge_pump_on}, {29'h0, e});
   endtask

   task automatic vr(input logic [15:0] idx);
      rd(ba(idx), mem[9'(idx - IDX_ARRAY)], RESP_OKAY, 1'b1);
   endtask

   task automatic upd(input logic [1:0] m, input logic [15:0] idx, input logic [7:0] d);
      logic [8:0] a;
      logic [1:0] bk;
      a  = 9'(idx - IDX_ARRAY);
      bk = a[8:7];
      if (idx == IDX_NV_CFG) begin
         if (m == MODE_PROG) nv = nv & d;
         else if (m == MODE_BYTE_ER) nv = ERASED;
      end else if (m == MODE_BULK_ER) begin
         if (shd[3:0] == 4'h0) foreach (mem[i]) mem[i] = ERASED;
      end else if (!shd[bk]) begin
         case (m)
            MODE_PROG:    mem[a] = mem[a] & d;
            MODE_BYTE_ER: mem[a] = ERASED;
            default:      for (int i = 0; i < 128; i++) mem[{bk, 7'(i)}] = ERASED;
         endcase
      end
   endtask

   // Full program or erase sequence, latch left clear at the end
   task automatic op(input logic [1:0] m, input logic [15:0] idx, input logic [7:0] d);
      logic [7:0] c;
      c = {3'h0, m, 3'h4};
      wr(ba(IDX_CTRL), c, RESP_OKAY);
      wr(ba(idx), d, RESP_OKAY);
      wr(ba(IDX_CTRL), c | 8'h01, RESP_OKAY);
      repeat (4) @(posedge aclk);
      wr(ba(IDX_CTRL), c, RESP_OKAY);
      wr(ba(IDX_CTRL), 8'h00, RESP_OKAY);
      upd(m, idx, d);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(15));
      foreach (mem[i]) mem[i] = ERASED;
      shd = NV_CFG_INIT & CFG_MASK;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ba(IDX_CTRL), 8'h00, RESP_OKAY, 1'b1);
      rd(ba(IDX_SHADOW), shd, RESP_OKAY, 1'b1);
      outs(3'h0);
      wr(ba(IDX_CTRL), 8'he2, RESP_OKAY);
      outs(3'h6);
      rd(ba(IDX_CTRL), 8'ha0, RESP_OKAY, 1'b1);
      rd(ba(IDX_ARRAY), 8'h00, RESP_OKAY, 1'b1);
      wr(ba(IDX_CTRL), 8'h00, RESP_OKAY);
      repeat (4) @(posedge aclk);
      rd(ba(16'h0100), 8'h00, RESP_SLVERR, 1'b0);
      wr(ba(16'h0100), 8'h5a, RESP_SLVERR);
      wr(ba(IDX_CTRL) + 18'h1, 8'h04, RESP_SLVERR);
      wr(ba(IDX_SHADOW), 8'h8f, RESP_OKAY);
      rd(ba(IDX_SHADOW), shd, RESP_OKAY, 1'b1);
      wr(ba(IDX_CTRL), 8'h01, RESP_OKAY);
      rd(ba(IDX_CTRL), 8'h00, RESP_OKAY, 1'b1);
      wr(ba(IDX_CTRL), 8'h04, RESP_OKAY);
      wr(ba(IDX_CTRL), 8'h05, RESP_OKAY);
      rd(ba(IDX_CTRL), 8'h04, RESP_OKAY, 1'b1);
      outs(3'h0);
      // Capture replaced by a later write, then programmed
      base = IDX_ARRAY + 16'($urandom_range(0, 511));
      dat  = 8'($urandom);
      wr(ba(base), 8'($urandom), RESP_OKAY);
      wr(ba(base ^ 16'h1), dat, RESP_OKAY);
      rd(ba(base ^ 16'h2), dat, RESP_OKAY, 1'b1);
      wr(ba(IDX_CTRL), 8'h05, RESP_OKAY);
      outs(3'h1);
      stop_mode <= 1'b1;
      outs(3'h0);
      rd(ba(IDX_CTRL), 8'h05, RESP_OKAY, 1'b1);
      stop_mode <= 1'b0;
      outs(3'h1);
      wr(ba(IDX_CTRL), 8'h01, RESP_OKAY);
      rd(ba(IDX_CTRL), 8'h05, RESP_OKAY, 1'b1);
      wr(ba(IDX_CTRL), 8'h00, RESP_OKAY);
      rd(ba(IDX_CTRL), 8'h04, RESP_OKAY, 1'b1);
      outs(3'h0);
      wr(ba(IDX_CTRL), 8'h00, RESP_OKAY);
      upd(MODE_PROG, base ^ 16'h1, dat);
      vr(base);
      vr(base ^ 16'h1);
      // Every mode on neighbouring bytes and blocks
      for (int i = 0; i < 8; i++) begin
         op(tbl[i], base ^ 16'(i & 1), 8'($urandom));
         vr(base);
         vr(base ^ 16'h1);
         vr(base ^ 16'h80);
      end
      // Config byte: erase, reload, protect and redundancy
      op(MODE_BYTE_ER, IDX_NV_CFG, 8'h00);
      rd(ba(IDX_SHADOW), shd, RESP_OKAY, 1'b1);
      rd(ba(IDX_NV_CFG), nv & CFG_MASK, RESP_OKAY, 1'b1);
      shd = nv & CFG_MASK;
      rd(ba(IDX_SHADOW), shd, RESP_OKAY, 1'b1);
      rd(ba(IDX_ARRAY + 16'h100), 8'h00, RESP_SLVERR, 1'b0);
      op(MODE_PROG, IDX_NV_CFG, 8'h01);
      rd(ba(IDX_NV_CFG), nv & CFG_MASK, RESP_OKAY, 1'b1);
      shd = nv & CFG_MASK;
      rd(ba(IDX_SHADOW), shd, RESP_OKAY, 1'b1);
      op(MODE_PROG, IDX_ARRAY + 16'h05, 8'h00);
      vr(IDX_ARRAY + 16'h05);
      op(MODE_PROG, IDX_ARRAY + 16'h85, 8'h00);
      vr(IDX_ARRAY + 16'h85);
      op(MODE_BULK_ER, IDX_ARRAY + 16'h85, 8'h00);
      vr(IDX_ARRAY + 16'h85);
      // Reset in mid-run: stored byte kept, shadow reloaded
      op(MODE_BYTE_ER, IDX_NV_CFG, 8'h00);
      rd(ba(IDX_SHADOW), shd, RESP_OKAY, 1'b1);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ba(IDX_SHADOW), nv & CFG_MASK, RESP_OKAY, 1'b1);
      rd(ba(IDX_NV_CFG), nv & CFG_MASK, RESP_OKAY, 1'b1);
      rd(ba(IDX_CTRL), 8'h00, RESP_OKAY, 1'b1);
      stop_test();
   end

endmodule
`default_nettype wire
